// [rtl/out_cfg_pkg.sv]
package out_cfg_pkg;
   localparam logic [9:0] OFS_DEVICE_INDEX = 10'h005;
   localparam logic [9:0] OFS_CLOCK_DIVIDER = 10'h00B;
   localparam logic [9:0] OFS_OUTPUT_MODE = 10'h014;
   localparam logic [9:0] OFS_OUTPUT_ADJUST = 10'h015;
   localparam logic [9:0] OFS_OUTPUT_PHASE = 10'h016;
   localparam logic [9:0] OFS_TRANSFER = 10'h0FF;
   localparam logic [9:0] OFS_RATE_OVERRIDE = 10'h100;
   localparam logic [9:0] OFS_USER_IO_TWO = 10'h101;
   localparam logic [9:0] OFS_USER_IO_THREE = 10'h102;
   localparam logic [7:0] MASK_DEVICE_INDEX = 8'h03;
   localparam logic [7:0] MASK_CLOCK_DIVIDER = 8'h07;
   localparam logic [7:0] MASK_OUTPUT_MODE = 8'h45;
   localparam logic [7:0] MASK_OUTPUT_ADJUST = 8'h31;
   localparam logic [7:0] MASK_OUTPUT_PHASE = 8'h7F;
   localparam logic [7:0] MASK_RATE_OVERRIDE = 8'h77;
   localparam logic [7:0] MASK_USER_IO_TWO = 8'h01;
   localparam logic [7:0] MASK_USER_IO_THREE = 8'h08;
   localparam logic [7:0] RST_DEVICE_INDEX = 8'h03;
   localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
   localparam logic [7:0] RST_OUTPUT_MODE = 8'h01;
   localparam logic [7:0] RST_OUTPUT_ADJUST = 8'h00;
   localparam logic [7:0] RST_OUTPUT_PHASE = 8'h03;
   localparam logic [7:0] RST_RATE_OVERRIDE = 8'h00;
   localparam logic [7:0] RST_USER_IO_TWO = 8'h00;
   localparam logic [7:0] RST_USER_IO_THREE = 8'h00;
   localparam int BIT_REDUCED_SWING = 6;
   localparam int BIT_INVERT = 2;
   localparam int BIT_TWOS_COMP = 0;
   localparam int TERM_HI = 5;
   localparam int TERM_LO = 4;
   localparam int BIT_DOUBLE_DRIVE = 0;
   localparam int SAMPLE_PHASE_HI = 6;
   localparam int SAMPLE_PHASE_LO = 4;
   localparam int CLOCK_PHASE_HI = 3;
   localparam int CLOCK_PHASE_LO = 0;
   localparam int RATE_CAP_HI = 2;
   localparam int RATE_CAP_LO = 0;
   localparam int BIT_TRANSFER = 0;
   localparam int BIT_PULLDOWN_OFF = 0;
   localparam int BIT_CM_POWER_DOWN = 3;
   localparam int DIVIDE_HI = 2;
   localparam int DIVIDE_LO = 0;
   localparam logic [3:0] CLOCK_PHASE_MAX = 4'hB;
   localparam logic [7:0] STEP_DEGREES = 8'h3C;
   localparam int CHANNELS = 2;
endpackage

// [rtl/lane_format_if.sv]
interface lane_format_if;
   logic [11:0] sample;
   logic invert;
   logic twos_comp;
   logic [11:0] coded;
   modport ctrl(output sample, output invert, output twos_comp, input coded);
   modport fmt(input sample, input invert, input twos_comp, output coded);
endinterface

// [rtl/lane_format.sv]
module lane_format
(
   lane_format_if.fmt port_f
);
   logic [11:0] binary;
   always_comb
   begin
      // Offset binary flips the sign bit
      binary = port_f.sample;
      if (!port_f.twos_comp)
      begin
         binary[11] = ~port_f.sample[11];
      end
      port_f.coded = port_f.invert ? ~binary : binary;
   end
endmodule

// [rtl/out_cfg_regs.sv]
// What this block does
// - Mode bit 6 set selects the reduced-swing driver, clear the standard.
// - Driver current follows the swing option, termination stays separate.
// - Mode bit 2 set inverts every serialized output bit.
// - Mode bit 0 resets to one for two's complement, zero gives offset.
// - Adjust bits 5 to 4 pick the internal termination resistor.
// - Adjust bit 0 doubles frame and bit clock drive for indexed channels.
// - A termination selection overrides double clock drive.
// - With the divider active, phase bits 6 to 4 delay sampling 0 to 7.
// - Phase bits 3 to 0 shift the bit clock in 60 degree steps, reset 180.
// - Override writes stay pending until transfer bit 0 is written one.
// - Override bits 2 to 0 cap the rate capability, never the real rate.
// - User control 2 bit 0 set disconnects the data pin pull-down.
// - User control 3 bit 3 set powers down the common mode generator.
// - All other writes apply at once, only the override waits.
// - Per-channel settings go to channels chosen by index bits 1 to 0.
module out_cfg_regs
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [9:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   input wire logic [11:0] sample_in,
   output logic [11:0] lane_data,
   output logic reduced_swing,
   output logic [1:0] drive_current_sel,
   output logic [1:0] termination_sel,
   output logic [1:0] word_framing_clock_out_double,
   output logic [1:0] bit_clock_out_double,
   output logic [2:0] sample_delay_cycles,
   output logic [9:0] bit_clock_out_phase_deg,
   output logic [1:0] active_resolution,
   output logic active_override_en,
   output logic [2:0] max_rate_cap,
   output logic sdio_pulldown_on,
   output logic common_mode_reference_pd
);
   logic [7:0] index_reg, index_next;
   logic [7:0] divider_reg, divider_next;
   logic [7:0] mode_reg, mode_next;
   logic [7:0] adjust_reg, adjust_next;
   logic [7:0] phase_reg, phase_next;
   logic [7:0] pend_reg, pend_next;
   logic [7:0] live_reg, live_next;
   logic [7:0] io_two_reg, io_two_next;
   logic [7:0] io_three_reg, io_three_next;
   logic [7:0] rd_reg, rd_next;
   logic [11:0] lane_reg, lane_next;
   logic [2:0] delay_reg, delay_next;
   logic [9:0] deg_reg, deg_next;
   logic [3:0] cphase;
   logic [7:0] wmask;

   lane_format_if fmt_bus ();
   lane_format fmt_u (.port_f(fmt_bus));

   assign wmask = wr_data;

   always_comb
   begin
      index_next = index_reg;
      divider_next = divider_reg;
      mode_next = mode_reg;
      adjust_next = adjust_reg;
      phase_next = phase_reg;
      pend_next = pend_reg;
      live_next = live_reg;
      io_two_next = io_two_reg;
      io_three_next = io_three_reg;
      if (wr_en)
      begin
         unique case (addr)
            out_cfg_pkg::OFS_DEVICE_INDEX:
            begin
               index_next = wmask & out_cfg_pkg::MASK_DEVICE_INDEX;
            end
            out_cfg_pkg::OFS_CLOCK_DIVIDER:
            begin
               divider_next = wmask & out_cfg_pkg::MASK_CLOCK_DIVIDER;
            end
            out_cfg_pkg::OFS_OUTPUT_MODE:
            begin
               mode_next = wmask & out_cfg_pkg::MASK_OUTPUT_MODE;
            end
            out_cfg_pkg::OFS_OUTPUT_ADJUST:
            begin
               adjust_next = wmask & out_cfg_pkg::MASK_OUTPUT_ADJUST;
            end
            out_cfg_pkg::OFS_OUTPUT_PHASE:
            begin
               phase_next = wmask & out_cfg_pkg::MASK_OUTPUT_PHASE;
            end
            out_cfg_pkg::OFS_TRANSFER:
            begin
               if (wmask[out_cfg_pkg::BIT_TRANSFER])
               begin
                  live_next = pend_reg;
               end
            end
            out_cfg_pkg::OFS_RATE_OVERRIDE:
            begin
               pend_next = wmask & out_cfg_pkg::MASK_RATE_OVERRIDE;
            end
            out_cfg_pkg::OFS_USER_IO_TWO:
            begin
               io_two_next = wmask & out_cfg_pkg::MASK_USER_IO_TWO;
            end
            out_cfg_pkg::OFS_USER_IO_THREE:
            begin
               io_three_next = wmask & out_cfg_pkg::MASK_USER_IO_THREE;
            end
            default:
            begin
            end
         endcase
      end
   end

   always_comb
   begin
      rd_next = rd_reg;
      if (rd_en)
      begin
         unique case (addr)
            out_cfg_pkg::OFS_DEVICE_INDEX: rd_next = index_reg;
            out_cfg_pkg::OFS_CLOCK_DIVIDER: rd_next = divider_reg;
            out_cfg_pkg::OFS_OUTPUT_MODE: rd_next = mode_reg;
            out_cfg_pkg::OFS_OUTPUT_ADJUST:
            begin
               rd_next = adjust_reg;
            end
            out_cfg_pkg::OFS_OUTPUT_PHASE: rd_next = phase_reg;
            out_cfg_pkg::OFS_RATE_OVERRIDE: rd_next = pend_reg;
            out_cfg_pkg::OFS_USER_IO_TWO: rd_next = io_two_reg;
            out_cfg_pkg::OFS_USER_IO_THREE: rd_next = io_three_reg;
            default: rd_next = 8'h00;
         endcase
      end
   end

   always_comb
   begin
      // Sampling phase only when divider is in use
      if (divider_reg[out_cfg_pkg::DIVIDE_HI:out_cfg_pkg::DIVIDE_LO] != 3'h0)
      begin
         delay_next = phase_reg[out_cfg_pkg::SAMPLE_PHASE_HI:
                                out_cfg_pkg::SAMPLE_PHASE_LO];
      end
      else
      begin
         delay_next = 3'h0;
      end
      cphase = phase_reg[out_cfg_pkg::CLOCK_PHASE_HI:
                         out_cfg_pkg::CLOCK_PHASE_LO];
      if (cphase > out_cfg_pkg::CLOCK_PHASE_MAX)
      begin
         deg_next = deg_reg;
      end
      else
      begin
         deg_next = 10'(cphase) *
            10'(out_cfg_pkg::STEP_DEGREES);
      end
   end

   assign fmt_bus.sample = sample_in;
   assign fmt_bus.invert = mode_reg[out_cfg_pkg::BIT_INVERT];
   assign fmt_bus.twos_comp = mode_reg[out_cfg_pkg::BIT_TWOS_COMP];
   assign lane_next = fmt_bus.coded;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         index_reg <= out_cfg_pkg::RST_DEVICE_INDEX;
         divider_reg <= out_cfg_pkg::RST_CLOCK_DIVIDER;
         mode_reg <= out_cfg_pkg::RST_OUTPUT_MODE;
         adjust_reg <= out_cfg_pkg::RST_OUTPUT_ADJUST;
         phase_reg <= out_cfg_pkg::RST_OUTPUT_PHASE;
         pend_reg <= out_cfg_pkg::RST_RATE_OVERRIDE;
         live_reg <= out_cfg_pkg::RST_RATE_OVERRIDE;
         io_two_reg <= out_cfg_pkg::RST_USER_IO_TWO;
         io_three_reg <= out_cfg_pkg::RST_USER_IO_THREE;
      end
      else
      begin
         index_reg <= index_next;
         divider_reg <= divider_next;
         mode_reg <= mode_next;
         adjust_reg <= adjust_next;
         phase_reg <= phase_next;
         pend_reg <= pend_next;
         live_reg <= live_next;
         io_two_reg <= io_two_next;
         io_three_reg <= io_three_next;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         rd_reg <= 8'h00;
      end
      else
      begin
         rd_reg <= rd_next;
      end
   end

   // Formatted lane word
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         lane_reg <= 12'h000;
      end
      else
      begin
         lane_reg <= lane_next;
      end
   end

   // Derived sampling delay and clock phase
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         delay_reg <= 3'h0;
         deg_reg <= 10'h0B4;
      end
      else
      begin
         delay_reg <= delay_next;
         deg_reg <= deg_next;
      end
   end

   assign rd_data = rd_reg;
   assign lane_data = lane_reg;
   assign reduced_swing = mode_reg[out_cfg_pkg::BIT_REDUCED_SWING];
   // Current tracks swing; termination independent
   assign drive_current_sel =
      {1'b0, mode_reg[out_cfg_pkg::BIT_REDUCED_SWING]};
   assign termination_sel =
      adjust_reg[out_cfg_pkg::TERM_HI:out_cfg_pkg::TERM_LO];
   // Clock drive per channel; termination wins
   for (genvar c = 0; c < out_cfg_pkg::CHANNELS; c++)
   begin : chan
      logic dbl_reg, dbl_next, dbl_out;
      always_comb
      begin
         dbl_next = dbl_reg;
         if (wr_en && addr == out_cfg_pkg::OFS_OUTPUT_ADJUST && index_reg[c])
         begin
            dbl_next = wr_data[out_cfg_pkg::BIT_DOUBLE_DRIVE];
         end
      end
      always_ff @(posedge ref_clk)
      begin
         if (!rst_b)
         begin
            dbl_reg <= 1'b0;
         end
         else
         begin
            dbl_reg <= dbl_next;
         end
      end
      always_comb
      begin
         if (termination_sel != 2'h0)
         begin
            dbl_out = 1'b0;
         end
         else
         begin
            dbl_out = dbl_reg;
         end
      end
      assign bit_clock_out_double[c] = dbl_out;
      assign word_framing_clock_out_double[c] = dbl_out;
   end
   assign sample_delay_cycles = delay_reg;
   assign bit_clock_out_phase_deg = deg_reg;
   assign active_resolution = live_reg[5:4];
   assign active_override_en = live_reg[6];
   // Capability cap only, not the sampling clock
   assign max_rate_cap =
      live_reg[out_cfg_pkg::RATE_CAP_HI:out_cfg_pkg::RATE_CAP_LO];
   assign sdio_pulldown_on =
      ~io_two_reg[out_cfg_pkg::BIT_PULLDOWN_OFF];
   assign common_mode_reference_pd =
      io_three_reg[out_cfg_pkg::BIT_CM_POWER_DOWN];
endmodule

// [tb/out_cfg_regs_sva.sv]
module out_cfg_regs_sva
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [9:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic reduced_swing,
   input wire logic [1:0] termination_sel,
   input wire logic [1:0] word_framing_clock_out_double,
   input wire logic [1:0] bit_clock_out_double,
   input wire logic [9:0] bit_clock_out_phase_deg,
   input wire logic [2:0] max_rate_cap,
   input wire logic sdio_pulldown_on,
   input wire logic common_mode_reference_pd
);
   timeunit 1ns;
   timeprecision 1ps;
   wire w_md = wr_en && addr == 10'h014;
   wire w_adj = wr_en && addr == 10'h015;
   wire w_ph = wr_en && addr == 10'h016;
   wire w_ovr = wr_en && addr == 10'h100;
   wire w_two = wr_en && addr == 10'h101;
   wire w_thr = wr_en && addr == 10'h102;
   wire [3:0] dbl = {word_framing_clock_out_double, bit_clock_out_double};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   chk_swing_taken:
      assert property (w_md |=> reduced_swing == $past(wr_data[6]))
      else $error("swing option wrong");
   chk_term_taken:
      assert property (w_adj |=> termination_sel == $past(wr_data[5:4]))
      else $error("termination wrong");
   chk_term_wins:
      assert property (termination_sel != 2'h0 |-> dbl == 4'h0)
      else $error("double drive with termination");
   chk_double_off:
      assert property (w_adj && !wr_data[0] && termination_sel == 2'h0
         |=> (dbl & ~$past(dbl)) == 4'h0)
      else $error("double drive raised by clear");
   chk_override_pending:
      assert property (w_ovr |=> $stable(max_rate_cap))
      else $error("override applied early");
   chk_pulldown_taken:
      assert property (w_two |=> sdio_pulldown_on == !$past(wr_data[0]))
      else $error("pull-down wrong");
   chk_cm_taken:
      assert property (w_thr |=> common_mode_reference_pd == $past(wr_data[3]))
      else $error("common mode power-down wrong");
   chk_phase_degrees:
      assert property (w_ph && wr_data[3:0] <= 4'hB |=> ##1
         bit_clock_out_phase_deg == 10'($past(wr_data[3:0], 2)) * 10'h03C)
      else $error("clock phase degrees wrong");
endmodule

// [tb/cfg_host.sv]
module cfg_host
(
   input wire logic ref_clk,
   output logic wr_en,
   output logic rd_en,
   output logic [9:0] addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_ratio = 3'h0;
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 10'h000;
      wr_data = 8'h00;
   end
   task automatic write_reg(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 10'h00B)
         div_ratio = d[2:0];
      if (a == 10'h016 && d[6:4] > div_ratio)
         v[6:4] = div_ratio;
      @(negedge ref_clk);
      wr_en = 1'b1;
      addr = a;
      wr_data = v;
      @(negedge ref_clk);
      wr_en = 1'b0;
      addr = ~a;
      wr_data = ~v;
   endtask
   task automatic read_reg(input logic [9:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge ref_clk);
      rd_en = 1'b0;
      addr = ~a;
      d = rd_data;
   endtask
endmodule

// [tb/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] sample_in = 12'h123;
   logic wr_en, rd_en, swing, oen, pd_on, cm_pd;
   logic [9:0] addr, deg;
   logic [7:0] wr_data, rd_data, rv, m;
   logic [11:0] lane, e, dg;
   logic [1:0] cur, term, fdbl, bdbl, res;
   logic [2:0] dly, cap;
   int n_errors = 0;
   int num_checks = 0;
   logic [9:0] ra [8] = '{10'h005, 10'h00B, 10'h014, 10'h015, 10'h016,
      10'h100, 10'h101, 10'h102};
   logic [7:0] rst_v [8] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00,
      8'h00, 8'h00};
   logic [7:0] msk [8] = '{8'h03, 8'h07, 8'h45, 8'h31, 8'h7F, 8'h77,
      8'h01, 8'h08};
   logic [7:0] md [4] = '{8'h45, 8'h00, 8'h04, 8'h01};
   logic [7:0] ph [4] = '{8'h5A, 8'h0C, 8'h3B, 8'h00};
   always #12.5 ref_clk = ~ref_clk;
   cfg_host host_u (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wr_data(wr_data), .rd_data(rd_data));
   out_cfg_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
      .sample_in(sample_in), .lane_data(lane), .reduced_swing(swing),
      .drive_current_sel(cur), .termination_sel(term),
      .word_framing_clock_out_double(fdbl), .bit_clock_out_double(bdbl),
      .sample_delay_cycles(dly), .bit_clock_out_phase_deg(deg),
      .active_resolution(res), .active_override_en(oen),
      .max_rate_cap(cap), .sdio_pulldown_on(pd_on),
      .common_mode_reference_pd(cm_pd));
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t reg %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_pin(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t pin %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      finish_test();
   end
   initial
   begin
      repeat (20) @(negedge ref_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         host_u.read_reg(ra[i], rv);
         check_reg(rv, rst_v[i]);
      end
      check_pin(12'(deg), 12'h0B4);
      check_pin(12'({pd_on, cm_pd}), 12'h002);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
         host_u.write_reg(ra[i], 8'hFF);
      for (int i = 0; i < 8; i++)
      begin
         host_u.read_reg(ra[i], rv);
         check_reg(rv, msk[i]);
      end
      host_u.read_reg(10'h0FF, rv);
      check_reg(rv, 8'h00);
      host_u.read_reg(10'h3FF, rv);
      check_reg(rv, 8'h00);
      check_pin(12'({swing, cur}), 12'h005);
      check_pin(12'({term, fdbl, bdbl}), 12'h030);
      check_pin(12'({pd_on, cm_pd}), 12'h001);
      check_pin(12'({oen, cap}), 12'h000);
      check_pin(12'(dly), 12'h007);
      check_pin(12'(deg), 12'h0B4);
      host_u.write_reg(10'h0FF, 8'h01);
      check_pin(12'({oen, res, cap}), 12'h03F);
      $display("test masks done");
      for (int i = 0; i < 4; i++)
      begin
         m = md[i];
         host_u.write_reg(10'h014, m);
         @(negedge ref_clk);
         e = sample_in ^ {~m[0], 11'h000};
         if (m[2])
            e = ~e;
         check_pin(lane, e);
      end
      check_pin(12'({swing, cur}), 12'h000);
      host_u.write_reg(10'h015, 8'h00);
      host_u.write_reg(10'h005, 8'h01);
      host_u.write_reg(10'h015, 8'h01);
      check_pin(12'({fdbl, bdbl}), 12'h005);
      host_u.write_reg(10'h015, 8'h11);
      check_pin(12'({term, fdbl, bdbl}), 12'h010);
      host_u.write_reg(10'h015, 8'h01);
      check_pin(12'({fdbl, bdbl}), 12'h005);
      host_u.write_reg(10'h015, 8'h00);
      check_pin(12'({fdbl, bdbl}), 12'h000);
      host_u.write_reg(10'h005, 8'h02);
      host_u.write_reg(10'h015, 8'h01);
      check_pin(12'({fdbl, bdbl}), 12'h00A);
      $display("test drive done");
      dg = 12'h0B4;
      for (int i = 0; i < 4; i++)
      begin
         host_u.write_reg(10'h016, ph[i]);
         @(negedge ref_clk);
         if (ph[i][3:0] <= 4'hB)
            dg = 12'(ph[i][3:0]) * 12'h03C;
         check_pin(12'(dly), 12'(ph[i][6:4]));
         check_pin(12'(deg), dg);
      end
      $display("test phase done");
      finish_test();
   end
endmodule
bind out_cfg_regs out_cfg_regs_sva chk_u
(
   .ref_clk(ref_clk), .rst_b(rst_b), .wr_en(wr_en), .addr(addr),
   .wr_data(wr_data), .reduced_swing(reduced_swing),
   .termination_sel(termination_sel),
   .word_framing_clock_out_double(word_framing_clock_out_double),
   .bit_clock_out_double(bit_clock_out_double),
   .bit_clock_out_phase_deg(bit_clock_out_phase_deg),
   .max_rate_cap(max_rate_cap), .sdio_pulldown_on(sdio_pulldown_on),
   .common_mode_reference_pd(common_mode_reference_pd)
);
